// ### hw/seq_device.sv
// Multichannel conversion sequencer, device end of the link.
// Assumes commands arrive as same-clock strobes; trigger and read clock
// are pins and are synchronised here. ADC code sampled at conversion end.
// Function
// - Command end starts sequence when trigger select 0
// - Trigger rising edge starts sequence when select 1
// - Convert enabled channels ascending, slot equals index
// - Loop mode wraps to first enabled channel
// - Loop mode stops on end/abort, restarts on start
// - Early start aborts, restarts at first channel outside step mode
// - Loop mode cycles until end or abort
// - Step mode advances pointer then waits idle
// - Step mode pointer wraps after last channel
// - Step mode left on end or abort
// - Step mode early start restarts same channel
// - Result shifted out serially after ready rises
// - First reading adds two system clock overhead
// - Later readings skip the fixed overhead
// - Channel delay counted in system clock ticks
// - Conversion time is one output data period
// - Results are 24-bit two's complement codes
// - Host scales code by ten over full scale
// - Diagnostic readings gain 2.5, supply thirty-two times
// - Die temperature 16-bit signed, host divides by 64
// - One-pass mode idles after last enabled channel
// - End waits for conversion, abort stops at once
module seq_device
  import seq_pkg::*;
#(
  parameter int CONV_T = CONV_TICKS
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  input  wire logic              I_PIN_TRIGGER_SEL,
  input  wire logic [CH_N-1:0]   I_CHANNEL_ENABLE_MASK,
  input  wire logic [5:0]        I_SETTLE_DELAY_CODE,
  input  wire logic [CODE_W-1:0] I_ADC_CODE,
  input  wire logic [TEMP_W-1:0] I_DIE_TEMP,
  output logic [3:0]             O_ACTIVE_CH,
  output logic                   O_BUSY,
  output logic                   O_CONVERTING,
  seq_link_if.dev                lnk
);

  generate
    if (CONV_T < 1 || CONV_T > 1023 || SYS_CLK_HZ > CLK_HZ) begin : g_chk
      $error("seq_device: unsupported timing parameters");
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers, stage 0 read only by stage 1
  logic [2:0] trig_s_ff;
  logic [2:0] rck_s_ff;
  wire        trig_rise = trig_s_ff[1] & ~trig_s_ff[2];
  wire        rck_rise  = rck_s_ff[1] & ~rck_s_ff[2];

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      trig_s_ff <= 3'h0;
      rck_s_ff  <= 3'h0;
    end else if (I_CE) begin
      trig_s_ff <= {trig_s_ff[1:0], lnk.trig};
      rck_s_ff  <= {rck_s_ff[1:0], lnk.rd_clk};
    end
  end

  // ==========================================================
  // System clock tick from the fast clock, fractional rate
  localparam logic [25:0] SYS_INC = 26'(SYS_CLK_HZ);
  localparam logic [25:0] CLK_MOD = 26'(CLK_HZ);
  logic [24:0] acc_ff;
  wire  [25:0] acc_sum = {1'b0, acc_ff} + SYS_INC;
  wire         tick    = acc_sum >= CLK_MOD;
  wire  [25:0] acc_wrp = acc_sum - CLK_MOD;
  wire  [24:0] nxt_acc = tick ? acc_wrp[24:0] : acc_sum[24:0];

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) acc_ff <= 25'h0;
    else if (I_CE) acc_ff <= nxt_acc;
  end

  // ==========================================================
  // Command decode and start event
  wire [CMD_W-1:0] code     = lnk.cmd_code;
  wire             c_one    = code == multi_channel_one_pass_cmd;
  wire             c_loop   = code == multi_channel_loop_cmd;
  wire             c_step   = code == multi_channel_step_cmd;
  wire             cmd_conv = lnk.cmd_valid & (c_one | c_loop | c_step);
  wire             cmd_end  = lnk.cmd_valid & (code == END_CMD);
  wire             cmd_abrt = lnk.cmd_valid & (code == ABORT_CMD);
  wire             cmd_temp = lnk.cmd_valid & (code == TEMP_READ_CMD);
  wire mode_t      cmd_mode = c_loop ? looping_mode
                            : c_step ? stepping_mode : one_pass_mode;

  state_t      st_ff;
  state_t      nxt_st;
  mode_t       mode_ff;
  logic        armed_ff;
  logic [3:0]  ptr_ff;
  logic [3:0]  nxt_ptr;
  logic [9:0]  cnt_ff;
  logic [9:0]  nxt_cnt;
  logic        endq_ff;
  logic        nxt_endq;

  // Trigger only counts once a conversion command has armed the mode
  wire start = I_PIN_TRIGGER_SEL ? (trig_rise & armed_ff)
                                 : cmd_conv;
  wire go    = start & (|I_CHANNEL_ENABLE_MASK);
  wire mode_t nmode = I_PIN_TRIGGER_SEL ? mode_ff : cmd_mode;

  // ==========================================================
  // Channel search over the enable mask
  function automatic logic [4:0] seek(input logic [CH_N-1:0] m,
                                      input logic [4:0] from);
    logic [4:0] r;
    r = 5'h10;
    for (int i = CH_N - 1; i >= 0; i--) begin
      if (m[i] && 5'(i) >= from) r = 5'(i);
    end
    return r;
  endfunction

  wire [4:0] first_w = seek(I_CHANNEL_ENABLE_MASK, 5'h00);
  wire [4:0] next_w  = seek(I_CHANNEL_ENABLE_MASK, {1'b0, ptr_ff} + 5'h01);
  wire       last_ch = next_w[4];
  wire [3:0] ptr_aft = last_ch ? first_w[3:0] : next_w[3:0];
  wire       keep    = (nmode == stepping_mode) &&
                       (mode_ff == stepping_mode) && (st_ff != ST_IDLE);
  wire [3:0] ptr_go  = keep ? ptr_ff : first_w[3:0];

  localparam logic [9:0] CNT_ONE   = 10'h001;
  localparam logic [9:0] FIXED_CNT = 10'(FIXED_TICKS);
  localparam logic [9:0] CONV_CNT  = 10'(CONV_T);
  localparam logic [9:0] DLY_MUL   = 10'(DELAY_MUL_TICKS);
  localparam logic [9:0] DLY_ADD   = 10'(DELAY_ADD_TICKS);
  wire [9:0] dly_cnt = 10'(I_SETTLE_DELAY_CODE) * DLY_MUL + DLY_ADD;
  wire       cnt_end = tick && (cnt_ff == CNT_ONE);
  wire       done    = (st_ff == ST_CONV) & cnt_end & ~cmd_abrt & ~go;

  // ==========================================================
  // Sequencer state machine
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_ptr  = ptr_ff;
    nxt_endq = endq_ff;
    if (cmd_abrt) begin
      nxt_st   = ST_IDLE;
      nxt_endq = 1'b0;
    end else if (go) begin
      nxt_st   = ST_FIXED;
      nxt_cnt  = FIXED_CNT;
      nxt_ptr  = ptr_go;
      nxt_endq = 1'b0;
    end else begin
      if (cmd_end) begin
        if (st_ff == ST_WAIT) nxt_st = ST_IDLE;
        else if (st_ff != ST_IDLE) nxt_endq = 1'b1;
      end
      unique case (st_ff)
        ST_IDLE, ST_WAIT: begin
        end
        ST_FIXED: begin
          if (tick) nxt_cnt = cnt_ff - CNT_ONE;
          if (cnt_end) begin
            nxt_st  = ST_DELAY;
            nxt_cnt = dly_cnt;
          end
        end
        ST_DELAY: begin
          if (tick) nxt_cnt = cnt_ff - CNT_ONE;
          if (cnt_end) begin
            nxt_st  = ST_CONV;
            nxt_cnt = CONV_CNT;
          end
        end
        ST_CONV: begin
          if (tick) nxt_cnt = cnt_ff - CNT_ONE;
          if (cnt_end) begin
            nxt_ptr  = ptr_aft;
            nxt_cnt  = dly_cnt;
            nxt_endq = 1'b0;
            if (endq_ff || cmd_end) nxt_st = ST_IDLE;
            else if (mode_ff == stepping_mode) nxt_st = ST_WAIT;
            else if (mode_ff == looping_mode) nxt_st = ST_DELAY;
            else nxt_st = last_ch ? ST_IDLE : ST_DELAY;
          end
        end
      endcase
    end
  end

  wire nxt_busy = (nxt_st != ST_IDLE) && (nxt_st != ST_WAIT);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_ff        <= ST_IDLE;
      cnt_ff       <= 10'h000;
      ptr_ff       <= 4'h0;
      endq_ff      <= 1'b0;
      O_BUSY       <= 1'b0;
      O_CONVERTING <= 1'b0;
    end else if (I_CE) begin
      st_ff        <= nxt_st;
      cnt_ff       <= nxt_cnt;
      ptr_ff       <= nxt_ptr;
      endq_ff      <= nxt_endq;
      O_BUSY       <= nxt_busy;
      O_CONVERTING <= nxt_st == ST_CONV;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode_ff  <= one_pass_mode;
      armed_ff <= 1'b0;
    end else if (I_CE) begin
      if (cmd_conv) mode_ff <= cmd_mode;
      if (cmd_conv) armed_ff <= 1'b1;
      else if (cmd_end || cmd_abrt) armed_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Result shifter, MSB first on each read clock rise
  localparam int PAD_W = CODE_W - TEMP_W;
  logic [CODE_W-1:0] shift_ff;
  logic              rdy_ff;
  wire  [CODE_W-1:0] temp_ext = {{PAD_W{I_DIE_TEMP[TEMP_W-1]}},
                                 I_DIE_TEMP};
  wire               load     = done | cmd_temp;
  wire  [CODE_W-1:0] load_val = done ? I_ADC_CODE : temp_ext;
  wire  [CODE_W-1:0] shifted  = {shift_ff[CODE_W-2:0], 1'b0};

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      shift_ff <= '0;
      rdy_ff   <= 1'b0;
    end else if (I_CE) begin
      if (load) shift_ff <= load_val;
      else if (rck_rise) shift_ff <= shifted;
      // A fresh result wins over a read edge in the same cycle
      if (load) rdy_ff <= 1'b1;
      else if (rck_rise || cmd_abrt) rdy_ff <= 1'b0;
    end
  end

  assign lnk.result_ready_pin = rdy_ff;
  assign lnk.rd_data          = shift_ff[CODE_W-1];
  assign O_ACTIVE_CH          = ptr_ff;

endmodule

// ### inc/seq_pkg.sv
// Shared constants and types for the conversion sequencer link.
// Assumes both ends run on the same 25 MHz clock.
package seq_pkg;

  // ==========================================================
  // Clocking and timing
  localparam int CLK_HZ          = 25000000;
  localparam int SYS_CLK_HZ      = 4608000;
  localparam int ODR_SPS         = 12000;
  localparam int CONV_TICKS      = SYS_CLK_HZ / ODR_SPS;
  localparam int FIXED_TICKS     = 2;
  localparam int DELAY_MUL_TICKS = 4;
  localparam int DELAY_ADD_TICKS = 8;
  localparam int RD_HALF         = 4;
  localparam int TRIG_HIGH       = 4;

  // ==========================================================
  // Widths
  localparam int CODE_W = 24;
  localparam int TEMP_W = 16;
  localparam int CH_N   = 16;
  localparam int CMD_W  = 4;

  // ==========================================================
  // Command codes
  localparam logic [CMD_W-1:0] multi_channel_one_pass_cmd = 4'h1;
  localparam logic [CMD_W-1:0] multi_channel_loop_cmd     = 4'h2;
  localparam logic [CMD_W-1:0] multi_channel_step_cmd     = 4'h3;
  localparam logic [CMD_W-1:0] END_CMD                    = 4'h4;
  localparam logic [CMD_W-1:0] ABORT_CMD                  = 4'h5;
  localparam logic [CMD_W-1:0] TEMP_READ_CMD              = 4'h6;

  // ==========================================================
  // Result scaling
  localparam int FULL_SCALE_UV = 10000000;
  localparam int LV_SCALE_UV   = 4000000;
  localparam int HIGH_POSITIVE_SUPPLY_MUL      = 32;
  localparam int HIGH_POSITIVE_SUPPLY_OFS_UV   = 250000;
  localparam int CDEG_PER_DEG  = 100;
  localparam int TEMP_SHIFT    = 6;
  localparam int RECIP_FRAC    = 12;

  typedef enum logic [2:0] {
    one_pass_mode = 3'b001,
    looping_mode  = 3'b010,
    stepping_mode = 3'b100
  } mode_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FIXED = 5'b00010,
    ST_DELAY = 5'b00100,
    ST_CONV  = 5'b01000,
    ST_WAIT  = 5'b10000
  } state_t;

endpackage

// ### inc/seq_link_if.sv
// Link between the sequencer device and its host controller.
// Assumes one shared clock; the testbench joins the two ends.
interface seq_link_if;
  import seq_pkg::*;
  logic             cmd_valid;
  logic [CMD_W-1:0] cmd_code;
  logic             trig;
  logic             rd_clk;
  logic             result_ready_pin;
  logic             rd_data;

  modport dev (
    input  cmd_valid,
    input  cmd_code,
    input  trig,
    input  rd_clk,
    output result_ready_pin,
    output rd_data
  );

  modport host (
    output cmd_valid,
    output cmd_code,
    output trig,
    output rd_clk,
    input  result_ready_pin,
    input  rd_data
  );
endinterface

// ### hw/seq_host.sv
// Host controller end: issues commands, pulses the trigger pin,
// fetches each result serially and scales it.
// Assumes the device end is joined through seq_link_if on one clock.
module seq_host
  import seq_pkg::*;
(
  input  wire logic               I_CLK,
  input  wire logic               I_RST,
  input  wire logic               I_CE,
  input  wire logic               I_CMD_VALID,
  input  wire logic [CMD_W-1:0]   I_CMD_CODE,
  input  wire logic               I_TRIG_REQ,
  input  wire logic [15:0]        I_GAIN_RECIP,
  output logic                    O_READING,
  output logic                    O_RESULT_VALID,
  output logic                    O_IS_TEMP,
  output logic [CODE_W-1:0]       O_RESULT,
  output logic signed [31:0]      O_HV_UV,
  output logic signed [31:0]      O_LV_UV,
  output logic signed [31:0]      O_HIGH_POSITIVE_SUPPLY_UV,
  output logic signed [31:0]      O_TEMP_CDEG,
  seq_link_if.host                lnk
);

  // ==========================================================
  // Command and trigger pins
  localparam logic [2:0] TRIG_CNT = 3'(TRIG_HIGH);
  logic             cv_ff;
  logic [CMD_W-1:0] cc_ff;
  logic             trig_ff;
  logic [2:0]       tcnt_ff;
  logic             is_temp_ff;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cv_ff      <= 1'b0;
      cc_ff      <= '0;
      trig_ff    <= 1'b0;
      tcnt_ff    <= 3'h0;
      is_temp_ff <= 1'b0;
    end else if (I_CE) begin
      cv_ff <= I_CMD_VALID;
      if (I_CMD_VALID) cc_ff <= I_CMD_CODE;
      if (I_CMD_VALID) is_temp_ff <= I_CMD_CODE == TEMP_READ_CMD;
      // Held high several cycles so the device synchroniser sees it
      if (I_TRIG_REQ && !trig_ff) begin
        trig_ff <= 1'b1;
        tcnt_ff <= TRIG_CNT;
      end else if (trig_ff) begin
        tcnt_ff <= tcnt_ff - 3'h1;
        if (tcnt_ff == 3'h1) trig_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Ready and data synchronisers, stage 0 read only by stage 1
  logic [2:0] rdy_s_ff;
  logic [1:0] dat_s_ff;
  wire        rdy_rise = rdy_s_ff[1] & ~rdy_s_ff[2];

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdy_s_ff <= 3'h0;
      dat_s_ff <= 2'h0;
    end else if (I_CE) begin
      rdy_s_ff <= {rdy_s_ff[1:0], lnk.result_ready_pin};
      dat_s_ff <= {dat_s_ff[0], lnk.rd_data};
    end
  end

  // ==========================================================
  // Serial fetch: sample each bit just before the next rising edge
  localparam logic [3:0] PH_HI   = 4'(RD_HALF);
  localparam logic [3:0] PH_LAST = 4'(2 * RD_HALF - 1);
  localparam logic [4:0] BIT_END = 5'(CODE_W - 1);
  logic [3:0]        ph_ff;
  logic [4:0]        bit_ff;
  logic              rck_ff;
  logic [CODE_W-1:0] sh_ff;
  wire  [CODE_W-1:0] word = {sh_ff[CODE_W-2:0], dat_s_ff[1]};
  wire               fin  = O_READING && ph_ff == 4'h0 && bit_ff == BIT_END;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_READING <= 1'b0;
      ph_ff     <= 4'h0;
      bit_ff    <= 5'h00;
      rck_ff    <= 1'b0;
      sh_ff     <= '0;
    end else if (I_CE) begin
      if (!O_READING) begin
        if (rdy_rise) O_READING <= 1'b1;
        ph_ff  <= 4'h0;
        bit_ff <= 5'h00;
      end else begin
        ph_ff <= (ph_ff == PH_LAST) ? 4'h0 : ph_ff + 4'h1;
        if (ph_ff == 4'h0) sh_ff <= word;
        // No rise on the closing sample, else the clock is left parked high
        if (ph_ff == 4'h0 && !fin) rck_ff <= 1'b1;
        if (ph_ff == PH_HI) rck_ff <= 1'b0;
        if (ph_ff == PH_LAST) bit_ff <= bit_ff + 5'h01;
        if (fin) O_READING <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Scaling of the finished word
  localparam logic signed [63:0] FS_UV   = 64'(FULL_SCALE_UV);
  localparam logic signed [63:0] LV_UV   = 64'(LV_SCALE_UV);
  localparam logic signed [63:0] HV_MUL  = 64'(HIGH_POSITIVE_SUPPLY_MUL);
  localparam logic signed [63:0] HV_OFS  = 64'(HIGH_POSITIVE_SUPPLY_OFS_UV);
  localparam logic signed [63:0] CDEG    = 64'(CDEG_PER_DEG);
  wire signed [63:0] code64 = 64'($signed(word));
  wire signed [63:0] recip  = $signed({48'h0, I_GAIN_RECIP});
  wire signed [63:0] hv_p   = (code64 * FS_UV * recip) >>>
                              (CODE_W + RECIP_FRAC);
  wire signed [63:0] lv_p   = (code64 * LV_UV) >>> CODE_W;
  wire signed [63:0] high_positive_supply_p = HV_MUL * (lv_p + HV_OFS);
  wire signed [63:0] tmp_p  = (code64 * CDEG) >>> TEMP_SHIFT;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RESULT_VALID <= 1'b0;
      O_IS_TEMP      <= 1'b0;
      O_RESULT       <= '0;
      O_HV_UV        <= 32'sh0;
      O_LV_UV        <= 32'sh0;
      O_HIGH_POSITIVE_SUPPLY_UV      <= 32'sh0;
      O_TEMP_CDEG    <= 32'sh0;
    end else if (I_CE) begin
      O_RESULT_VALID <= fin;
      if (fin) begin
        O_IS_TEMP   <= is_temp_ff;
        O_RESULT    <= word;
        O_HV_UV     <= hv_p[31:0];
        O_LV_UV     <= lv_p[31:0];
        O_HIGH_POSITIVE_SUPPLY_UV   <= high_positive_supply_p[31:0];
        O_TEMP_CDEG <= tmp_p[31:0];
      end
    end
  end

  assign lnk.cmd_valid = cv_ff;
  assign lnk.cmd_code  = cc_ff;
  assign lnk.trig      = trig_ff;
  assign lnk.rd_clk    = rck_ff;

endmodule

// ### dv/seq_link_asserts.sv
// Checker on the sequencer link between the device and host ends.
// Assumes one clock and an asynchronous active-high reset.
module seq_link_asserts
  import seq_pkg::*;
(
  input wire logic             I_CLK,
  input wire logic             I_RST,
  input wire logic             cmd_valid,
  input wire logic [CMD_W-1:0] cmd_code,
  input wire logic             trig,
  input wire logic             rd_clk,
  input wire logic             result_ready_pin,
  input wire logic             rd_data
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  wire abort_now = cmd_valid && (cmd_code == ABORT_CMD);
  wire temp_now  = cmd_valid && (cmd_code == TEMP_READ_CMD);

  property p_reset_idle;
    $fell(I_RST) |-> !result_ready_pin && !trig && !rd_clk;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link not idle after reset");

  property p_trig_width;
    $rose(trig) |-> trig[*4] ##1 !trig;
  endproperty
  a_trig_width: assert property (p_trig_width)
    else $error("trigger pulse width wrong");

  property p_rck_high;
    $rose(rd_clk) |-> rd_clk[*4] ##1 !rd_clk;
  endproperty
  a_rck_high: assert property (p_rck_high)
    else $error("read clock high phase wrong");

  property p_rck_low;
    $fell(rd_clk) |-> !rd_clk[*4];
  endproperty
  a_rck_low: assert property (p_rck_low)
    else $error("read clock low phase too short");

  // Host must begin its fetch soon after ready rises
  property p_fetch_start;
    $rose(result_ready_pin) |-> ##[2:8] $rose(rd_clk);
  endproperty
  a_fetch_start: assert property (p_fetch_start)
    else $error("no fetch after ready");

  property p_ready_clear;
    $rose(rd_clk) && result_ready_pin |-> ##[1:4] !result_ready_pin;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("ready not cleared by fetch");

  property p_ready_hold;
    result_ready_pin && !rd_clk && !abort_now |=> result_ready_pin;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped without fetch");

  property p_abort_clear;
    abort_now |=> !result_ready_pin;
  endproperty
  a_abort_clear: assert property (p_abort_clear)
    else $error("ready survived abort");

  property p_temp_ready;
    temp_now |-> ##[1:3] result_ready_pin;
  endproperty
  a_temp_ready: assert property (p_temp_ready)
    else $error("no ready after temperature read");

  // Shift lags the clock rise, so the sampled bit is steady
  property p_data_steady;
    $rose(rd_clk) |-> $stable(rd_data) ##1 $stable(rd_data);
  endproperty
  a_data_steady: assert property (p_data_steady)
    else $error("serial data moved at sampling");

  c_fetch: cover property ($rose(result_ready_pin));
  c_trig:  cover property ($rose(trig));
  c_abort: cover property (abort_now);
endmodule

// ### dv/tb_top.sv
// Bench joining the device and host ends over the link.
// Assumes seq_pkg, seq_link_if and both design ends are compiled first.
module tb_top
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals and instances
  // Short conversion keeps the run brief, yet outlasts a fetch
  localparam int CT = 40;
  logic                    clk       = 1'b0;
  logic                    rst       = 1'b1;
  logic                    sel       = 1'b0;
  logic                    cmd_v     = 1'b0;
  logic                    trig_req  = 1'b0;
  logic                    conv_q    = 1'b0;
  logic [CMD_W-1:0]        cmd_c     = 4'h0;
  logic [CH_N-1:0]         mask      = 16'h0000;
  logic [5:0]              dly       = 6'h00;
  logic [CODE_W-1:0]       adc       = 24'h000000;
  logic [TEMP_W-1:0]       temp      = 16'hFF80;
  logic [15:0]             recip     = 16'h1000;
  logic [3:0]              act_ch;
  logic                    busy;
  logic                    conv;
  logic                    rv;
  logic                    rdg;
  logic                    is_t;
  logic [CODE_W-1:0]       res;
  logic signed [31:0]      hv;
  logic signed [31:0]      lv;
  logic signed [31:0]      high_positive_supply;
  logic signed [31:0]      tc;
  int                      error_cnt = 0;
  int                      compares  = 0;
  int                      cyc       = 0;
  int                      conv_t[$];

  seq_link_if lnk ();

  seq_device #(.CONV_T(CT)) u_seq_device (
    .I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_PIN_TRIGGER_SEL(sel),
    .I_CHANNEL_ENABLE_MASK(mask), .I_SETTLE_DELAY_CODE(dly),
    .I_ADC_CODE(adc), .I_DIE_TEMP(temp), .O_ACTIVE_CH(act_ch),
    .O_BUSY(busy), .O_CONVERTING(conv), .lnk(lnk));

  seq_host u_seq_host (
    .I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_CMD_VALID(cmd_v),
    .I_CMD_CODE(cmd_c), .I_TRIG_REQ(trig_req), .I_GAIN_RECIP(recip),
    .O_READING(rdg), .O_RESULT_VALID(rv), .O_IS_TEMP(is_t), .O_RESULT(res),
    .O_HV_UV(hv), .O_LV_UV(lv), .O_HIGH_POSITIVE_SUPPLY_UV(high_positive_supply), .O_TEMP_CDEG(tc),
    .lnk(lnk));

  seq_link_asserts u_seq_link_asserts (
    .I_CLK(clk), .I_RST(rst), .cmd_valid(lnk.cmd_valid),
    .cmd_code(lnk.cmd_code), .trig(lnk.trig), .rd_clk(lnk.rd_clk),
    .result_ready_pin(lnk.result_ready_pin), .rd_data(lnk.rd_data));

  always #20 clk = ~clk;

  // Code reveals which channel was converted
  function automatic logic [CODE_W-1:0] code_of(input logic [3:0] ch);
    if (ch == 4'h0)
      return 24'h800000;
    if (ch == 4'hC)
      return 24'h7FFFFF;
    return {8'h12, 12'h345, ch};
  endfunction

  always @(negedge clk) adc <= code_of(act_ch);

  always @(posedge clk) begin
    cyc    <= cyc + 1;
    conv_q <= conv;
    if (conv && !conv_q)
      conv_t.push_back(cyc);
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int v, input int lo,
                         input int hi);
    compares++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic send(input logic [CMD_W-1:0] c);
    @(negedge clk);
    cmd_v = 1'b1;
    cmd_c = c;
    @(negedge clk);
    cmd_v = 1'b0;
  endtask

  task automatic pulse();
    @(negedge clk);
    trig_req = 1'b1;
    @(negedge clk);
    trig_req = 1'b0;
  endtask

  task automatic expect_res(input logic [CODE_W-1:0] e);
    int n;
    n = 0;
    while (rv !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("result seen", 32'h1, 32'(rv));
    chk("reading done", 32'h0, 32'(rdg));
    chk("result", 32'(e), 32'(res));
    @(negedge clk);
  endtask

  task automatic wait_conv(input logic [3:0] ch);
    int n;
    n = 0;
    while ((conv !== 1'b1 || act_ch !== ch) && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("converting", 32'h1, 32'(conv));
    chk("conv channel", 32'(ch), 32'(act_ch));
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    int t0;
    int n;
    logic [3:0] chs[4];
    chs = '{4'h0, 4'h4, 4'h8, 4'hC};
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("busy", 32'h0, 32'(busy));
    chk("pointer", 32'h0, 32'(act_ch));
    send(multi_channel_one_pass_cmd);
    cycles(40);
    chk("empty busy", 32'h0, 32'(busy));
    chk("empty runs", 32'h0, conv_t.size());
    mask = 16'h1111;
    dly  = 6'h11;
    t0   = cyc;
    send(multi_channel_one_pass_cmd);
    foreach (chs[i]) expect_res(code_of(chs[i]));
    chk_rng("first period", conv_t[0] - t0, 416, 434);
    chk_rng("next period", conv_t[1] - conv_t[0], 628, 631);
    chk_rng("last period", conv_t[3] - conv_t[2], 628, 631);
    chk("pointer wrap", 32'h0, 32'(act_ch));
    cycles(700);
    chk("one pass", 32'h4, conv_t.size());
    mask = 16'h1001;
    dly  = 6'h00;
    send(multi_channel_loop_cmd);
    expect_res(code_of(4'h0));
    chk("hv min", -5000000, hv);
    chk("adc flag", 32'h0, 32'(is_t));
    chk("lv min", -2000000, lv);
    chk("high_positive_supply min", -56000000, high_positive_supply);
    expect_res(code_of(4'hC));
    chk("hv max", 4999999, hv);
    chk("lv max", 1999999, lv);
    chk("high_positive_supply max", 71999968, high_positive_supply);
    repeat (2) begin
      expect_res(code_of(4'h0));
      expect_res(code_of(4'hC));
    end
    wait_conv(4'h0);
    send(END_CMD);
    expect_res(code_of(4'h0));
    chk("end idle", 32'h0, 32'(busy));
    n = conv_t.size();
    cycles(600);
    chk("end stays", n, conv_t.size());
    send(multi_channel_loop_cmd);
    expect_res(code_of(4'h0));
    wait_conv(4'hC);
    send(multi_channel_loop_cmd);
    expect_res(code_of(4'h0));
    wait_conv(4'hC);
    send(ABORT_CMD);
    cycles(4);
    chk("abort idle", 32'h0, 32'(busy));
    n = conv_t.size();
    cycles(600);
    chk("abort stays", n, conv_t.size());
    sel  = 1'b1;
    mask = 16'h0110;
    send(multi_channel_step_cmd);
    cycles(60);
    chk("armed only", 32'h0, 32'(busy));
    pulse();
    expect_res(code_of(4'h4));
    chk("step wait", 32'h0, 32'(busy));
    chk("step next", 32'h8, 32'(act_ch));
    pulse();
    expect_res(code_of(4'h8));
    chk("step wrap", 32'h4, 32'(act_ch));
    pulse();
    expect_res(code_of(4'h4));
    pulse();
    wait_conv(4'h8);
    pulse();
    expect_res(code_of(4'h8));
    chk("same channel", 32'h4, 32'(act_ch));
    send(END_CMD);
    sel = 1'b0;
    send(TEMP_READ_CMD);
    expect_res(24'hFFFF80);
    chk("temp flag", 32'h1, 32'(is_t));
    chk("temp scaled", -200, tc);
    end_sim();
  end

  // Run needs roughly ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
